// *** rtl/bd_engine.sv ***
// Buffer descriptor engine: ownership, toggle check, stall, byte count
`timescale 1ns/1ps
`default_nettype none
module bd_engine (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Token from the packet layer
	input wire logic i_tok_valid,
	input wire bd_pkg::tok_t i_tok,
	output logic o_tok_ready,
	// OUT data from the host
	input wire logic i_rx_valid,
	input wire bd_pkg::rx_beat_t i_rx,
	output logic o_rx_ready,
	// IN data to the host
	output logic o_tx_valid,
	output bd_pkg::tx_beat_t o_tx,
	input wire logic i_tx_ready,
	// Handshake to the host
	output logic o_hs_valid,
	output logic [3:0] o_hs_pid,
	// Engine port of the USB RAM
	output logic [9:0] o_ram_addr,
	output logic o_ram_we,
	output logic [7:0] o_ram_wdata,
	input wire logic [7:0] i_ram_rdata,
	// Events and endpoint stall
	output logic o_stat_push,
	output logic [5:0] o_stat_bd,
	output logic o_trn_done,
	output logic o_stall_irq,
	output logic o_ep_stall,
	input wire logic i_ep_stall_clr
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [9:0] bd_loc(input logic [5:0] n, input logic [1:0] f);
		bd_loc = bd_pkg::BDT_BASE + {2'h0, n, f};
	endfunction

	function automatic logic [15:0] step(input logic [15:0] p, input logic hold);
		step = hold ? p : 16'(p + 16'h0001);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	bd_pkg::state_t st_ff, nxt_st;
	bd_pkg::kind_t kind_ff, kind_d;
	bd_pkg::tok_t tok_ff;
	logic [7:0] stat_ff, cnt_lo_ff, adrl_ff;
	logic [15:0] ptr_ff;
	logic [9:0] done_ff, iss_ff;
	logic err_ff, ovf_ff, bad_ff, rd_wait_ff, rd_pend_ff, lastp_ff;
	logic hs_pend_ff;
	logic [3:0] res_ff;
	logic tok_rdy_ff, rx_rdy_ff;
	logic hs_v_ff, push_ev_ff, trn_ff, irq_ff, ep_stall_ff;
	logic [3:0] hs_pid_ff;
	logic [9:0] ram_a_ff;
	logic ram_we_ff;
	logic [7:0] ram_d_ff;
	bd_pkg::tx_beat_t head_ff, tail_ff;
	logic hv_ff, tv_ff;

	// ----------------------------------------
	// Decodes
	// ----------------------------------------
	wire tok_take = i_tok_valid & tok_rdy_ff;
	wire rx_take = i_rx_valid & rx_rdy_ff;
	wire is_in = (tok_ff.pid == bd_pkg::PID_IN);
	wire is_setup = (tok_ff.pid == bd_pkg::PID_SETUP);
	// R1 ownership test
	wire own = stat_ff[bd_pkg::OWN_BIT];
	wire keep = stat_ff[bd_pkg::KEEP_BIT];
	wire incd = stat_ff[bd_pkg::INCD_BIT];
	wire tchk = stat_ff[bd_pkg::TCHK_BIT];
	wire tog = stat_ff[bd_pkg::TOG_BIT];
	wire buffer_stall = stat_ff[bd_pkg::STALL_BIT];
	// R15 ten-bit count
	wire [9:0] cnt_w = {stat_ff[1:0], cnt_lo_ff};
	// R12 expected toggle only with checking
	wire bad_b = tchk & (i_rx.data1 != tog);
	wire ovf_b = ~i_rx.empty & (done_ff == cnt_w);
	wire drop = (kind_ff != bd_pkg::K_NORM);
	// R10 mismatch never writes RAM
	wire wr_ok = rx_take & ~i_rx.empty & ~drop & ~bad_b & ~bad_ff & ~ovf_b;
	wire err_n = err_ff | i_rx.err;
	wire ovf_n = ovf_ff | ovf_b;
	wire bad_n = bad_ff | bad_b;
	wire zl_push = (st_ff == bd_pkg::S_TX) & (cnt_w == 10'h000) & ~tv_ff;
	wire can_iss = (st_ff == bd_pkg::S_TX) & ~rd_wait_ff & ~rd_pend_ff & ~tv_ff & (iss_ff != cnt_w);
	wire push_v = rd_pend_ff | zl_push;
	wire pop = hv_ff & i_tx_ready;
	// R6 R21 status rewrite with PID and count
	wire [7:0] wb_norm = {keep, stat_ff[bd_pkg::TOG_BIT], tok_ff.pid, done_ff[9:8]};
	wire [7:0] wb_srec = stat_ff & ~8'h84;
	wire [7:0] wb_stat = (kind_ff == bd_pkg::K_SREC) ? wb_srec : wb_norm;
	bd_pkg::tx_beat_t push_d;
	assign push_d.data = rd_pend_ff ? i_ram_rdata : 8'h00;
	assign push_d.last = rd_pend_ff ? lastp_ff : 1'b1;
	assign push_d.empty = ~rd_pend_ff;

	// R13 R14 outcome before any data moves
	always_comb begin
		kind_d = bd_pkg::K_NORM;
		if (!own) begin
			kind_d = bd_pkg::K_NAK;
		end else if (buffer_stall) begin
			kind_d = is_setup ? bd_pkg::K_SREC : bd_pkg::K_STALL;
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		unique case (st_ff)
			bd_pkg::S_IDLE: begin
				if (tok_take) begin
					nxt_st = bd_pkg::S_RC;
				end
			end
			bd_pkg::S_RC: nxt_st = bd_pkg::S_RL;
			bd_pkg::S_RL: nxt_st = bd_pkg::S_RH;
			bd_pkg::S_RH: nxt_st = bd_pkg::S_RA;
			bd_pkg::S_RA: nxt_st = bd_pkg::S_DEC;
			bd_pkg::S_DEC: begin
				if (!is_in) begin
					nxt_st = bd_pkg::S_RX;
				end else if (kind_d == bd_pkg::K_NORM) begin
					nxt_st = bd_pkg::S_TX;
				end else begin
					nxt_st = bd_pkg::S_HS;
				end
			end
			bd_pkg::S_RX: begin
				if (rx_take && i_rx.last) begin
					if (kind_ff == bd_pkg::K_SREC) begin
						nxt_st = bd_pkg::S_WBS;
					end else if (drop || err_n || ovf_n || bad_n) begin
						nxt_st = bd_pkg::S_HS;
					end else begin
						nxt_st = bd_pkg::S_WBC;
					end
				end
			end
			bd_pkg::S_TX: begin
				if (push_v && push_d.last) begin
					nxt_st = bd_pkg::S_WBC;
				end
			end
			bd_pkg::S_WBC: nxt_st = bd_pkg::S_WBS;
			bd_pkg::S_WBS: nxt_st = hs_pend_ff ? bd_pkg::S_HS : bd_pkg::S_IDLE;
			bd_pkg::S_HS: nxt_st = bd_pkg::S_IDLE;
			default: nxt_st = bd_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_ff <= bd_pkg::S_IDLE;
			tok_rdy_ff <= 1'b0;
			rx_rdy_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			tok_rdy_ff <= (nxt_st == bd_pkg::S_IDLE);
			rx_rdy_ff <= (nxt_st == bd_pkg::S_RX);
		end
	end

	// ----------------------------------------
	// Descriptor capture
	// ----------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tok_ff <= '0;
			stat_ff <= 8'h00;
			cnt_lo_ff <= 8'h00;
			adrl_ff <= 8'h00;
			kind_ff <= bd_pkg::K_NORM;
		end else begin
			if (tok_take) begin
				tok_ff <= i_tok;
			end
			// R4 status read first, firmware wrote it last
			if (st_ff == bd_pkg::S_RL) begin
				stat_ff <= i_ram_rdata;
			end
			if (st_ff == bd_pkg::S_RH) begin
				cnt_lo_ff <= i_ram_rdata;
			end
			if (st_ff == bd_pkg::S_RA) begin
				adrl_ff <= i_ram_rdata;
			end
			if (st_ff == bd_pkg::S_DEC) begin
				kind_ff <= kind_d;
			end
		end
	end

	// ----------------------------------------
	// Pointer and counts
	// ----------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ptr_ff <= 16'h0000;
			done_ff <= 10'h000;
			iss_ff <= 10'h000;
			rd_wait_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			lastp_ff <= 1'b0;
		end else begin
			// Read data lags the presented address by one cycle
			rd_wait_ff <= can_iss;
			rd_pend_ff <= rd_wait_ff;
			if (st_ff == bd_pkg::S_DEC) begin
				// R23 start at descriptor address
				ptr_ff <= {i_ram_rdata, adrl_ff};
				// R16 IN reports bytes sent
				done_ff <= is_in ? cnt_w : 10'h000;
				iss_ff <= 10'h000;
			end else if (wr_ok || can_iss) begin
				// R8 advance unless increment disabled
				ptr_ff <= step(ptr_ff, incd);
			end
			// R17 OUT counts bytes received
			if (wr_ok) begin
				done_ff <= 10'(done_ff + 10'h001);
			end
			if (can_iss) begin
				iss_ff <= 10'(iss_ff + 10'h001);
				lastp_ff <= (10'(iss_ff + 10'h001) == cnt_w);
			end
		end
	end

	// ----------------------------------------
	// Packet checks
	// ----------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			err_ff <= 1'b0;
			ovf_ff <= 1'b0;
			bad_ff <= 1'b0;
		end else if (st_ff == bd_pkg::S_DEC) begin
			err_ff <= 1'b0;
			ovf_ff <= 1'b0;
			bad_ff <= 1'b0;
		end else if (rx_take) begin
			err_ff <= err_n;
			// R18 oversize packet noted
			ovf_ff <= ovf_n;
			// R9 mismatch noted, answer stays ACK
			bad_ff <= bad_n;
		end
	end

	// ----------------------------------------
	// Handshake choice
	// ----------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			res_ff <= bd_pkg::PID_NAK;
			hs_pend_ff <= 1'b0;
		end else if (st_ff == bd_pkg::S_DEC) begin
			// R13 stall answer
			res_ff <= (kind_d == bd_pkg::K_STALL) ? bd_pkg::PID_STALL : bd_pkg::PID_NAK;
			hs_pend_ff <= ~(is_in & (kind_d == bd_pkg::K_NORM)) & (kind_d != bd_pkg::K_SREC);
		end else if (rx_take && i_rx.last && !drop) begin
			// R18 NACK on oversize or error
			res_ff <= (err_n | ovf_n) ? bd_pkg::PID_NAK : bd_pkg::PID_ACK;
		end
	end

	// ----------------------------------------
	// RAM port
	// ----------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ram_a_ff <= 10'h000;
			ram_we_ff <= 1'b0;
			ram_d_ff <= 8'h00;
		end else begin
			ram_we_ff <= wr_ok | (st_ff == bd_pkg::S_WBC) | (st_ff == bd_pkg::S_WBS);
			if (tok_take) begin
				ram_a_ff <= bd_loc(i_tok.bd, bd_pkg::F_STAT);
			end else if (st_ff == bd_pkg::S_RC) begin
				ram_a_ff <= bd_loc(tok_ff.bd, bd_pkg::F_CNT);
			end else if (st_ff == bd_pkg::S_RL) begin
				ram_a_ff <= bd_loc(tok_ff.bd, bd_pkg::F_ADRL);
			end else if (st_ff == bd_pkg::S_RH) begin
				ram_a_ff <= bd_loc(tok_ff.bd, bd_pkg::F_ADRH);
			end else if (wr_ok || can_iss) begin
				ram_a_ff <= ptr_ff[9:0];
				ram_d_ff <= i_rx.data;
			end else if (st_ff == bd_pkg::S_WBC) begin
				// R15 R16 R17 count low byte written back
				ram_a_ff <= bd_loc(tok_ff.bd, bd_pkg::F_CNT);
				ram_d_ff <= done_ff[7:0];
			end else if (st_ff == bd_pkg::S_WBS) begin
				// R5 R7 owner handed back unless kept, R14 stall SETUP always
				ram_a_ff <= bd_loc(tok_ff.bd, bd_pkg::F_STAT);
				ram_d_ff <= wb_stat;
			end
		end
	end

	// ----------------------------------------
	// Two-entry IN buffer
	// ----------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			head_ff <= '0;
			tail_ff <= '0;
			hv_ff <= 1'b0;
			tv_ff <= 1'b0;
		end else if (pop && tv_ff) begin
			head_ff <= tail_ff;
			tv_ff <= push_v;
			if (push_v) begin
				tail_ff <= push_d;
			end
		end else if (pop) begin
			hv_ff <= push_v;
			head_ff <= push_d;
		end else if (push_v && !hv_ff) begin
			head_ff <= push_d;
			hv_ff <= 1'b1;
		end else if (push_v) begin
			tail_ff <= push_d;
			tv_ff <= 1'b1;
		end
	end

	// ----------------------------------------
	// Events
	// ----------------------------------------
	wire fin = (st_ff == bd_pkg::S_WBS) & (kind_ff == bd_pkg::K_NORM);
	wire stall_now = (st_ff == bd_pkg::S_HS) & (res_ff == bd_pkg::PID_STALL);

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hs_v_ff <= 1'b0;
			hs_pid_ff <= bd_pkg::PID_NAK;
			push_ev_ff <= 1'b0;
			trn_ff <= 1'b0;
			irq_ff <= 1'b0;
			ep_stall_ff <= 1'b0;
		end else begin
			hs_v_ff <= (st_ff == bd_pkg::S_HS);
			if (st_ff == bd_pkg::S_HS) begin
				hs_pid_ff <= res_ff;
			end
			// R7 R11 events only when handed back
			push_ev_ff <= fin & ~keep;
			trn_ff <= fin & ~keep;
			// R13 stall interrupt
			irq_ff <= stall_now;
			// R22 set wins over firmware clear
			ep_stall_ff <= stall_now | (ep_stall_ff & ~i_ep_stall_clr);
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// R3 CPU side of the RAM is never gated here
	assign o_tok_ready = tok_rdy_ff;
	assign o_rx_ready = rx_rdy_ff;
	assign o_tx_valid = hv_ff;
	assign o_tx = head_ff;
	assign o_hs_valid = hs_v_ff;
	assign o_hs_pid = hs_pid_ff;
	assign o_ram_addr = ram_a_ff;
	assign o_ram_we = ram_we_ff;
	assign o_ram_wdata = ram_d_ff;
	assign o_stat_push = push_ev_ff;
	assign o_stat_bd = tok_ff.bd;
	assign o_trn_done = trn_ff;
	assign o_stall_irq = irq_ff;
	assign o_ep_stall = ep_stall_ff;

endmodule
`default_nettype wire

// *** rtl/bd_pkg.sv ***
// Shared constants and types for the buffer descriptor engine
// Overview of operation
// R1 - Status bit 7 marks engine ownership
// R2 - Firmware leaves engine-owned descriptors untouched
// R3 - No blocking of CPU access to RAM
// R4 - Firmware writes status byte last when arming
// R5 - Owner cleared on completion unless keep/stall
// R6 - Engine rewrites status with PID and count
// R7 - Keep-enabled holds ownership, no events raised
// R8 - Address steps per byte unless increment disabled
// R9 - Toggle mismatch still answered with ACK
// R10 - Mismatch drops data, no update, owner kept
// R11 - Good OUT acked, handed back, events raised
// R12 - Expected toggle used only when checking enabled
// R13 - Buffer stall answers STALL, flags, no change
// R14 - SETUP on stalled descriptor clears, hands back
// R15 - Ten-bit count split over two bytes
// R16 - IN sends count bytes, writes back sent
// R17 - OUT count is limit, writes back received
// R18 - Oversize OUT gets NACK, count unchanged
// R19 - Firmware presets owner flag before enabling
// R20 - Keep-enabled meant for streaming port only
// R21 - Engine status bits 5:2 hold token PID
// R22 - Endpoint stall flag holds until cleared
// R23 - Transfer starts at descriptor buffer address
package bd_pkg;

	// ----------------------------------------
	// Descriptor layout
	// ----------------------------------------
	localparam int unsigned OWN_BIT = 7;
	localparam int unsigned TOG_BIT = 6;
	localparam int unsigned KEEP_BIT = 5;
	localparam int unsigned INCD_BIT = 4;
	localparam int unsigned TCHK_BIT = 3;
	localparam int unsigned STALL_BIT = 2;
	localparam logic [1:0] F_STAT = 2'h0;
	localparam logic [1:0] F_CNT = 2'h1;
	localparam logic [1:0] F_ADRL = 2'h2;
	localparam logic [1:0] F_ADRH = 2'h3;
	localparam logic [9:0] BDT_BASE = 10'h000;

	// ----------------------------------------
	// Token and handshake PIDs
	// ----------------------------------------
	localparam logic [3:0] PID_OUT = 4'h1;
	localparam logic [3:0] PID_IN = 4'h9;
	localparam logic [3:0] PID_SETUP = 4'hD;
	localparam logic [3:0] PID_ACK = 4'h2;
	localparam logic [3:0] PID_NAK = 4'hA;
	localparam logic [3:0] PID_STALL = 4'hE;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [3:0] pid;
		logic [5:0] bd;
	} tok_t;

	typedef struct packed {
		logic [7:0] data;
		logic last;
		logic empty;
		logic data1;
		logic err;
	} rx_beat_t;

	typedef struct packed {
		logic [7:0] data;
		logic last;
		logic empty;
	} tx_beat_t;

	typedef enum logic [1:0] {
		K_NORM = 2'h0,
		K_NAK = 2'h1,
		K_STALL = 2'h2,
		K_SREC = 2'h3
	} kind_t;

	typedef enum logic [10:0] {
		S_IDLE = 11'h001,
		S_RC = 11'h002,
		S_RL = 11'h004,
		S_RH = 11'h008,
		S_RA = 11'h010,
		S_DEC = 11'h020,
		S_RX = 11'h040,
		S_TX = 11'h080,
		S_WBC = 11'h100,
		S_WBS = 11'h200,
		S_HS = 11'h400
	} state_t;

endpackage

// *** verif/bd_engine_properties.sv ***
// Port relations of the buffer descriptor engine
`timescale 1ns/1ps
`default_nettype none
module bd_engine_checker (
	// Watched ports
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_tok_valid,
	input wire bd_pkg::tok_t i_tok,
	input wire logic o_tok_ready,
	input wire logic o_hs_valid,
	input wire logic [3:0] o_hs_pid,
	input wire logic [9:0] o_ram_addr,
	input wire logic o_ram_we,
	input wire logic o_stat_push,
	input wire logic o_trn_done,
	input wire logic o_stall_irq,
	input wire logic o_ep_stall,
	input wire logic i_ep_stall_clr
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	property p_desc_read;
		i_tok_valid && o_tok_ready |=> o_ram_addr == {2'h0, $past(i_tok.bd), 2'h0}
			##1 o_ram_addr == {2'h0, $past(i_tok.bd, 2), 2'h1};
	endproperty
	a_desc_read: assert property (p_desc_read) else $error("descriptor read order");
	property p_push_after_stat;
		o_stat_push |-> o_ram_we && o_ram_addr[1:0] == bd_pkg::F_STAT
			&& $past(o_ram_we) && $past(o_ram_addr[1:0]) == bd_pkg::F_CNT;
	endproperty
	a_push_after_stat: assert property (p_push_after_stat) else $error("push without status");
	property p_done_push;
		o_trn_done |-> o_stat_push;
	endproperty
	a_done_push: assert property (p_done_push) else $error("done without push");
	property p_hs_pulse;
		o_hs_valid |=> !o_hs_valid;
	endproperty
	a_hs_pulse: assert property (p_hs_pulse) else $error("handshake not a pulse");
	property p_stall_hs;
		o_stall_irq |-> o_hs_valid && o_hs_pid == bd_pkg::PID_STALL;
	endproperty
	a_stall_hs: assert property (p_stall_hs) else $error("stall irq without STALL");
	property p_ep_set;
		o_stall_irq |-> ##[0:1] o_ep_stall;
	endproperty
	a_ep_set: assert property (p_ep_set) else $error("stall flag not set");
	property p_ep_hold;
		o_ep_stall && !i_ep_stall_clr |=> o_ep_stall;
	endproperty
	a_ep_hold: assert property (p_ep_hold) else $error("stall flag dropped");
	property p_ep_clr;
		i_ep_stall_clr && o_tok_ready |=> !o_ep_stall;
	endproperty
	a_ep_clr: assert property (p_ep_clr) else $error("stall flag not cleared");
endmodule
bind bd_engine bd_engine_checker i_bd_engine_checker (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
	.i_tok_valid(i_tok_valid), .i_tok(i_tok), .o_tok_ready(o_tok_ready), .o_hs_valid(o_hs_valid),
	.o_hs_pid(o_hs_pid), .o_ram_addr(o_ram_addr), .o_ram_we(o_ram_we), .o_stat_push(o_stat_push),
	.o_trn_done(o_trn_done), .o_stall_irq(o_stall_irq), .o_ep_stall(o_ep_stall),
	.i_ep_stall_clr(i_ep_stall_clr));
`default_nettype wire

// *** verif/bd_ram_model.sv ***
// Synchronous USB RAM behind the engine port
`timescale 1ns/1ps
`default_nettype none
module bd_ram_model (
	// Engine port
	input wire logic i_clk_sys,
	input wire logic [9:0] i_addr,
	input wire logic i_we,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [1024];
	always @(posedge i_clk_sys) begin
		if (i_we)
			mem[i_addr] <= i_wdata;
		o_rdata <= mem[i_addr];
	end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the buffer descriptor engine
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic i_clk_sys = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_tok_valid = 1'b0;
	bd_pkg::tok_t i_tok = '0;
	logic i_rx_valid = 1'b0;
	bd_pkg::rx_beat_t i_rx = '0;
	logic i_tx_ready = 1'b0;
	logic i_ep_stall_clr = 1'b0;
	logic o_tok_ready, o_rx_ready, o_tx_valid, o_hs_valid, o_ram_we, o_stat_push;
	logic o_trn_done, o_stall_irq, o_ep_stall, eep = 1'b0;
	bd_pkg::tx_beat_t o_tx;
	bd_pkg::tx_beat_t txq [$];
	logic [3:0] o_hs_pid, hpid;
	logic [9:0] o_ram_addr;
	logic [7:0] o_ram_wdata, i_ram_rdata;
	logic [5:0] o_stat_bd, cur_bd;
	logic [7:0] exp_mem [1024];
	logic [7:0] exq [$];
	int fail_count = 0, n_compared = 0, nhs, npush, ndone, nirq, seed = 32'hc41422f4;
	bd_engine i_bd_engine (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_tok_valid(i_tok_valid),
		.i_tok(i_tok), .o_tok_ready(o_tok_ready), .i_rx_valid(i_rx_valid), .i_rx(i_rx),
		.o_rx_ready(o_rx_ready), .o_tx_valid(o_tx_valid), .o_tx(o_tx), .i_tx_ready(i_tx_ready),
		.o_hs_valid(o_hs_valid), .o_hs_pid(o_hs_pid), .o_ram_addr(o_ram_addr), .o_ram_we(o_ram_we),
		.o_ram_wdata(o_ram_wdata), .i_ram_rdata(i_ram_rdata), .o_stat_push(o_stat_push),
		.o_stat_bd(o_stat_bd), .o_trn_done(o_trn_done), .o_stall_irq(o_stall_irq),
		.o_ep_stall(o_ep_stall), .i_ep_stall_clr(i_ep_stall_clr));
	bd_ram_model i_bd_ram_model (.i_clk_sys(i_clk_sys), .i_addr(o_ram_addr), .i_we(o_ram_we),
		.i_wdata(o_ram_wdata), .o_rdata(i_ram_rdata));
	always #25 i_clk_sys = ~i_clk_sys;
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		if (fail_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic guard(input logic ok, input string what);
		if (ok !== 1'b1) begin
			fail_count++;
			$display("ERROR %s expected done seen timeout", what);
			close_out();
		end
	endtask
	task automatic put(input logic [9:0] a, input logic [7:0] v);
		i_bd_ram_model.mem[a] = v;
		exp_mem[a] = v;
	endtask
	// ----------------------------------------
	// Host side monitor
	// ----------------------------------------
	always @(posedge i_clk_sys) begin
		if (o_hs_valid) begin
			nhs++;
			hpid = o_hs_pid;
		end
		if (o_stat_push) begin
			npush++;
			check("stat_bd", 16'(o_stat_bd), 16'(cur_bd));
		end
		ndone += o_trn_done;
		nirq += o_stall_irq;
		if (o_tx_valid && i_tx_ready)
			txq.push_back(o_tx);
		i_tx_ready <= 1'($random(seed));
	end
	// ----------------------------------------
	// One transaction against the model
	// ----------------------------------------
	task automatic run(input logic [3:0] pid, input logic [5:0] bd, input logic [7:0] st,
			input logic [7:0] c8, input logic [9:0] ad, input int n, input logic d1);
		int lim, i, k, ecnt;
		logic ok, wr, ehs, ev, eirq;
		logic [3:0] epid;
		logic [7:0] b [$];
		lim = {st[1:0], c8};
		// descriptor set while firmware owns it
		put({2'h0, bd, 2'h1}, c8);
		put({2'h0, bd, 2'h2}, ad[7:0]);
		put({2'h0, bd, 2'h3}, {6'h0, ad[9:8]});
		put({2'h0, bd, 2'h0}, st);
		cur_bd = bd;
		nhs = 0;
		npush = 0;
		ndone = 0;
		nirq = 0;
		txq.delete();
		exq.delete();
		@(posedge i_clk_sys);
		i_tok_valid <= 1'b1;
		i_tok <= '{pid: pid, bd: bd};
		k = 0;
		do begin
			@(posedge i_clk_sys);
			k++;
		end while (!o_tok_ready && k < 99);
		guard(o_tok_ready, "tok");
		i_tok_valid <= 1'b0;
		for (i = 0; i < n; i++) begin
			b.push_back(8'($random(seed)));
			i_rx_valid <= 1'b1;
			i_rx <= '{data: b[i], last: i == n - 1, empty: 1'b0, data1: d1, err: 1'b0};
			k = 0;
			do begin
				@(posedge i_clk_sys);
				k++;
			end while (!o_rx_ready && k < 99);
			guard(o_rx_ready, "rx");
		end
		i_rx_valid <= 1'b0;
		ehs = 1'b1;
		epid = bd_pkg::PID_NAK;
		ev = 1'b0;
		eirq = 1'b0;
		wr = 1'b0;
		ecnt = 0;
		if (st[7] && st[2] && pid == bd_pkg::PID_SETUP) begin
			ehs = 1'b0;
			exp_mem[{bd, 2'h0}] = st & 8'h7B;
		end else if (st[7] && st[2]) begin
			epid = bd_pkg::PID_STALL;
			eirq = 1'b1;
			eep = 1'b1;
		end else if (st[7] && pid == bd_pkg::PID_IN) begin
			ehs = 1'b0;
			wr = 1'b1;
			n = lim;
			ecnt = (lim == 0) ? 1 : lim;
			for (i = 0; i < lim; i++)
				exq.push_back(exp_mem[ad + (st[4] ? 0 : i)]);
		end else if (st[7]) begin
			ok = !(st[3] && d1 != st[6]);
			for (i = 0; i < n && i < lim && ok; i++)
				exp_mem[ad + (st[4] ? 0 : i)] = b[i];
			epid = (n > lim) ? bd_pkg::PID_NAK : bd_pkg::PID_ACK;
			wr = ok && n <= lim;
		end
		if (wr) begin
			exp_mem[{bd, 2'h1}] = n[7:0];
			exp_mem[{bd, 2'h0}] = {st[5], st[6], pid, n[9:8]};
			ev = !st[5];
		end
		k = 0;
		do begin
			@(posedge i_clk_sys);
			k++;
		end while ((!o_tok_ready || txq.size() < ecnt) && k < 3000);
		guard(o_tok_ready && txq.size() >= ecnt, "idle");
		repeat (3) @(posedge i_clk_sys);
		check("hs_count", 16'(nhs), 16'(ehs));
		if (ehs)
			check("hs_pid", 16'(hpid), 16'(epid));
		check("push", 16'(npush), 16'(ev));
		check("done", 16'(ndone), 16'(ev));
		check("stall_irq", 16'(nirq), 16'(eirq));
		check("ep_stall", 16'(o_ep_stall), 16'(eep));
		check("tx_count", 16'(txq.size()), 16'(ecnt));
		for (i = 0; i < exq.size() && i < txq.size(); i++)
			check("tx_data", 16'(txq[i].data), 16'(exq[i]));
		if (ecnt > 0 && txq.size() > 0)
			check("tx_end", {14'h0, txq[$].last, txq[$].empty}, {14'h0, 1'b1, lim == 0});
		for (i = 0; i < 1024; i++)
			check("ram", 16'(i_bd_ram_model.mem[i]), 16'(exp_mem[i]));
	endtask
	initial begin
		for (int i = 0; i < 1024; i++)
			put(i[9:0], 8'($random(seed)));
		repeat (6) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		run(bd_pkg::PID_OUT, 6'h01, 8'h80, 8'h05, 10'h100, 3, 1'b0);
		run(bd_pkg::PID_OUT, 6'h02, 8'h88, 8'h04, 10'h110, 2, 1'b1);
		run(bd_pkg::PID_OUT, 6'h03, 8'hD8, 8'h04, 10'h120, 3, 1'b1);
		run(bd_pkg::PID_OUT, 6'h04, 8'h80, 8'h02, 10'h130, 3, 1'b0);
		// keep-enabled run stands in for streaming
		run(bd_pkg::PID_OUT, 6'h05, 8'hA0, 8'h04, 10'h140, 4, 1'b0);
		run(bd_pkg::PID_SETUP, 6'h06, 8'h80, 8'h08, 10'h150, 8, 1'b0);
		run(bd_pkg::PID_IN, 6'h07, 8'h81, 8'h02, 10'h200, 0, 1'b0);
		run(bd_pkg::PID_IN, 6'h08, 8'hD0, 8'h04, 10'h300, 0, 1'b0);
		run(bd_pkg::PID_IN, 6'h09, 8'h80, 8'h00, 10'h310, 0, 1'b0);
		run(bd_pkg::PID_IN, 6'h0A, 8'h00, 8'h03, 10'h320, 0, 1'b0);
		run(bd_pkg::PID_OUT, 6'h0B, 8'hC5, 8'h02, 10'h330, 2, 1'b0);
		run(bd_pkg::PID_SETUP, 6'h0B, 8'hC5, 8'h02, 10'h330, 2, 1'b0);
		i_ep_stall_clr <= 1'b1;
		@(posedge i_clk_sys);
		i_ep_stall_clr <= 1'b0;
		eep = 1'b0;
		repeat (2) @(posedge i_clk_sys);
		check("ep_clear", 16'(o_ep_stall), 16'(eep));
		close_out();
	end
endmodule
`default_nettype wire
